/* inc/dual_timer_defines.svh */
// offsets, field positions, reset values and counts of the dual timer block
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH
// register indexes, byte address is four times the index
`define IDX_C0_HIGH      8'h0D
`define IDX_C0_LOW       8'h0C
`define IDX_C0_CTRL      8'h0E
`define IDX_C1_HIGH      8'h10
`define IDX_C1_LOW       8'h0F
`define IDX_C1_CTRL      8'h11
`define IDX_INT_CTRL     8'h0B
`define IDX_INT_STATUS   8'h30
`define IDX_INT_MASK     8'h31
// control field positions
`define CTRL_EDGE_BIT    3
`define CTRL_EN_BIT      4
`define CTRL_MODE_LSB    6
`define CTRL_RESET       8'h08
`define CTRL_WMASK       8'hD8
// interrupt control field positions
`define INTC_COUNTER0_INTERRUPT_ENABLE_BIT    2
`define INTC_COUNTER1_INTERRUPT_ENABLE_BIT    3
`define INTC_T0F_BIT     5
`define INTC_T1F_BIT     6
`define INTC_WMASK       8'h7F
// internal clock divider
`define PRESCALE_DIV     2'h3
`define COUNT_MAX        16'hFFFF
`endif

/* inc/dual_timer_pkg.sv */
// types shared by the dual timer block
package dual_timer_pkg;
    typedef enum logic [3:0] {
        MODE_UNUSED = 4'b0001,
        MODE_EVENT  = 4'b0010,
        MODE_TIMER  = 4'b0100,
        MODE_PULSE  = 4'b1000
    } mode_t;
    typedef enum logic [2:0] {
        PW_ARMED   = 3'b001,
        PW_COUNT   = 3'b010,
        PW_DONE    = 3'b100
    } pw_state_t;
    typedef struct packed {
        logic [1:0] mode;
        logic       enable;
        logic       edge_sel;
    } ctrl_t;
endpackage : dual_timer_pkg

/* rtl/dual_timer_event_counter.sv */
// two 16-bit timer event counters behind an ahb-lite slave
// Functional notes
// - two 16-bit up counters, timer at clock over four, event from pin
// - low byte writes go to buffer, moved in on high byte write
// - reading low byte returns low byte buffer
// - mode bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused
// - counter 0 flag at interrupt control bit 5, counter 1 bit 6
// - event mode: edge bit 1 counts falling, 0 counts rising
// - pulse mode: edge bit 1 starts rising stops falling, else inverse
// - pulse mode: return to original level stops and clears enable
// - after one measurement hold result until enable set again
// - pulse mode overflow also reloads and raises interrupt
// - control bit 4 enables counting, only software clears it otherwise
// - counter overflow acts as a wake-up source
// - interrupt enable bit at 0 disables that counter interrupt
// - control bits 0 to 2 and 5 read as zero
// - preload write loads counter when disabled, only preload when enabled
// - counter clock blocked during a software read of its high or low byte
`include "dual_timer_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_timer_event_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    input  wire logic [1:0]  pin_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             irq_out,
    output logic             wakeup_out
);
    // decode of mode field
    // mode field decode
    function automatic dual_timer_pkg::mode_t decode_mode(input logic [1:0] m);
        case (m)
            2'b01:   decode_mode = dual_timer_pkg::MODE_EVENT;
            2'b10:   decode_mode = dual_timer_pkg::MODE_TIMER;
            2'b11:   decode_mode = dual_timer_pkg::MODE_PULSE;
            default: decode_mode = dual_timer_pkg::MODE_UNUSED;
        endcase
    endfunction : decode_mode

    // address phase capture
    logic        dwr_reg;
    logic        drd_reg;
    logic [7:0]  didx_reg;
    logic        aphase;
    logic [7:0]  aidx;
    assign aphase = hsel_in && hready_in && htrans_in[1] && clk_en_in;
    assign aidx   = haddr_in[9:2];

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dwr_reg  <= 1'b0;
            drd_reg  <= 1'b0;
            didx_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            dwr_reg  <= aphase && hwrite_in;
            drd_reg  <= aphase && !hwrite_in;
            didx_reg <= aidx;
        end
    end

    // pin synchronisers, two flops then edge history
    logic [1:0] pin_s1_reg;
    logic [1:0] pin_s2_reg;
    logic [1:0] pin_d_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_s1_reg <= 2'b00;
            pin_s2_reg <= 2'b00;
            pin_d_reg  <= 2'b00;
        end
        else if (clk_en_in)
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    // internal clock divider, one tick every four clocks
    logic [1:0] pre_reg;
    logic       tick;
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pre_reg <= 2'h0;
        else if (clk_en_in)
            pre_reg <= pre_reg + 2'h1;
    end
    assign tick = (pre_reg == `PRESCALE_DIV);

    // interrupt control register, sticky status and mask
    logic [7:0] intc_reg;
    logic [1:0] ist_reg;
    logic [1:0] imask_reg;
    logic [1:0] ovf;
    logic [1:0] low_hit;
    logic [1:0] high_hit;
    logic [1:0] ctrl_hit;
    logic [1:0] cnt_rd;
    logic [WIDTH-1:0] cnt_reg [2];
    logic [WIDTH-1:0] pre_ld_reg [2];
    logic [7:0]       lowbuf_reg [2];
    dual_timer_pkg::ctrl_t ctrl_reg [2];
    logic             intc_wr;
    logic             ist_wr;
    logic             imask_wr;

    assign intc_wr  = dwr_reg && (didx_reg == `IDX_INT_CTRL);
    assign ist_wr   = dwr_reg && (didx_reg == `IDX_INT_STATUS);
    assign imask_wr = dwr_reg && (didx_reg == `IDX_INT_MASK);

    // per counter logic
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ctr
            localparam logic [7:0] IDX_H = (g == 0) ? `IDX_C0_HIGH : `IDX_C1_HIGH;
            localparam logic [7:0] IDX_L = (g == 0) ? `IDX_C0_LOW : `IDX_C1_LOW;
            localparam logic [7:0] IDX_C = (g == 0) ? `IDX_C0_CTRL : `IDX_C1_CTRL;
            dual_timer_pkg::mode_t     mode;
            dual_timer_pkg::pw_state_t pw_reg;
            logic rise;
            logic fall;
            logic start_edge;
            logic stop_edge;
            logic step;
            logic hi_wr;
            logic ctrl_wr;

            assign mode  = decode_mode(ctrl_reg[g].mode);
            assign rise  = pin_s2_reg[g] && !pin_d_reg[g];
            assign fall  = !pin_s2_reg[g] && pin_d_reg[g];
            assign start_edge = ctrl_reg[g].edge_sel ? rise : fall;
            assign stop_edge  = ctrl_reg[g].edge_sel ? fall : rise;
            assign hi_wr    = dwr_reg && (didx_reg == IDX_H);
            assign ctrl_wr  = dwr_reg && (didx_reg == IDX_C);
            assign low_hit[g]  = (didx_reg == IDX_L);
            assign high_hit[g] = (didx_reg == IDX_H);
            assign ctrl_hit[g] = (didx_reg == IDX_C);
            // read blocks counting for the read cycle
            assign cnt_rd[g] = aphase && !hwrite_in && (aidx == IDX_H || aidx == IDX_L);

            // count qualifier per mode
            always_comb
            begin
                step = 1'b0;
                case (mode)
                    dual_timer_pkg::MODE_EVENT:
                        step = ctrl_reg[g].edge_sel ? fall : rise;
                    dual_timer_pkg::MODE_TIMER:
                        step = tick;
                    dual_timer_pkg::MODE_PULSE:
                        step = tick && (pw_reg == dual_timer_pkg::PW_COUNT) && !stop_edge;
                    default:
                        step = 1'b0;
                endcase
                step = step && ctrl_reg[g].enable && !cnt_rd[g];
            end
            assign ovf[g] = step && (cnt_reg[g] == `COUNT_MAX);

            always_ff @(posedge mclk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    lowbuf_reg[g] <= 8'h00;
                else if (clk_en_in && dwr_reg && low_hit[g])
                    lowbuf_reg[g] <= hwdata_in[7:0];
            end

            // preload register
            always_ff @(posedge mclk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    pre_ld_reg[g] <= '0;
                else if (clk_en_in && hi_wr)
                    pre_ld_reg[g] <= {hwdata_in[7:0], lowbuf_reg[g]};
            end

            // counter register
            always_ff @(posedge mclk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    cnt_reg[g] <= '0;
                else if (clk_en_in)
                begin
                    // preload write loads only when disabled
                    if (hi_wr && !ctrl_reg[g].enable)
                        cnt_reg[g] <= {hwdata_in[7:0], lowbuf_reg[g]};
                    else if (ovf[g])
                        cnt_reg[g] <= pre_ld_reg[g];
                    else if (step)
                        cnt_reg[g] <= cnt_reg[g] + 1'b1;
                end
            end

            // pulse width sequencer
            always_ff @(posedge mclk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    pw_reg <= dual_timer_pkg::PW_ARMED;
                else if (clk_en_in)
                begin
                    // rearm only when enable set again
                    if (ctrl_wr && hwdata_in[`CTRL_EN_BIT])
                        pw_reg <= dual_timer_pkg::PW_ARMED;
                    else if (mode == dual_timer_pkg::MODE_PULSE && ctrl_reg[g].enable)
                    begin
                        case (pw_reg)
                            dual_timer_pkg::PW_ARMED:
                                if (start_edge)
                                    pw_reg <= dual_timer_pkg::PW_COUNT;
                            dual_timer_pkg::PW_COUNT:
                                if (stop_edge)
                                    pw_reg <= dual_timer_pkg::PW_DONE;
                            default:
                                pw_reg <= pw_reg;
                        endcase
                    end
                end
            end

            // control register
            always_ff @(posedge mclk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    ctrl_reg[g] <= '{mode:     2'(`CTRL_RESET >> `CTRL_MODE_LSB),
                                     enable:   1'(`CTRL_RESET >> `CTRL_EN_BIT),
                                     edge_sel: 1'(`CTRL_RESET >> `CTRL_EDGE_BIT)};
                else if (clk_en_in)
                begin
                    if (ctrl_wr)
                    begin
                        ctrl_reg[g].mode     <= hwdata_in[`CTRL_MODE_LSB +: 2];
                        ctrl_reg[g].enable   <= hwdata_in[`CTRL_EN_BIT];
                        ctrl_reg[g].edge_sel <= hwdata_in[`CTRL_EDGE_BIT];
                    end
                    else if (mode == dual_timer_pkg::MODE_PULSE && ctrl_reg[g].enable
                             && pw_reg == dual_timer_pkg::PW_COUNT && stop_edge)
                        ctrl_reg[g].enable <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt control register with hardware set flags
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            intc_reg <= 8'h00;
        else if (clk_en_in)
        begin
            if (intc_wr)
                intc_reg <= hwdata_in[7:0] & `INTC_WMASK;
            // flag positions, set wins over write
            if (ovf[0])
                intc_reg[`INTC_T0F_BIT] <= 1'b1;
            if (ovf[1])
                intc_reg[`INTC_T1F_BIT] <= 1'b1;
        end
    end

    // sticky status, write one clears, set wins
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            ist_reg <= 2'b00;
        else if (clk_en_in)
            ist_reg <= (ist_reg & ~(ist_wr ? hwdata_in[1:0] : 2'b00)) | ovf;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            imask_reg <= 2'b00;
        else if (clk_en_in && imask_wr)
            imask_reg <= hwdata_in[1:0];
    end

    // interrupt and wake outputs
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_out    <= 1'b0;
            wakeup_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // per counter interrupt enable gates the request
            irq_out <= |(ist_reg & imask_reg &
                         {intc_reg[`INTC_COUNTER1_INTERRUPT_ENABLE_BIT], intc_reg[`INTC_COUNTER0_INTERRUPT_ENABLE_BIT]});
            wakeup_out <= |ovf;
        end
    end

    // read data mux
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        if (low_hit[0])
            rd_byte = lowbuf_reg[0];
        else if (low_hit[1])
            rd_byte = lowbuf_reg[1];
        else if (high_hit[0])
            rd_byte = cnt_reg[0][15:8];
        else if (high_hit[1])
            rd_byte = cnt_reg[1][15:8];
        else if (ctrl_hit[0])
            rd_byte = {ctrl_reg[0].mode, 1'b0, ctrl_reg[0].enable,
                       ctrl_reg[0].edge_sel, 3'b000};
        else if (ctrl_hit[1])
            rd_byte = {ctrl_reg[1].mode, 1'b0, ctrl_reg[1].enable,
                       ctrl_reg[1].edge_sel, 3'b000};
        else if (didx_reg == `IDX_INT_CTRL)
            rd_byte = intc_reg;
        else if (didx_reg == `IDX_INT_STATUS)
            rd_byte = {6'h00, ist_reg};
        else if (didx_reg == `IDX_INT_MASK)
            rd_byte = {6'h00, imask_reg};
    end

    // bus answer, one wait state on reads, none on writes
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else if (clk_en_in)
        begin
            hrdata_out    <= (aphase && !hwrite_in) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            // read data is registered from the data phase index, so stretch reads by one clock
            hreadyout_out <= !(aphase && !hwrite_in);
            hresp_out     <= 1'b0;
        end
    end
endmodule : dual_timer_event_counter
`default_nettype wire

/* testbench/pin_source_model.sv */
// far-side source of the two counter input pins
`timescale 1ns/1ns
`default_nettype none
module pin_source_model (
    input  wire logic       mclk_in,
    output logic      [1:0] pin_out
);
    // both pins start low
    initial pin_out = 2'b00;
    // pin edges
    // sets one pin level after an edge and holds it for some clocks
    task automatic drive(input int ch, input logic lvl, input int hold);
        @(posedge mclk_in);
        pin_out[ch] <= lvl;
        repeat (hold) @(posedge mclk_in);
    endtask : drive
endmodule : pin_source_model
`default_nettype wire

/* testbench/dual_timer_event_counter_properties.sv */
// port assertions of the dual timer block
`include "dual_timer_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_timer_properties (
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    input wire logic        clk_en_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [2:0]  hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [1:0]  pin_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        irq_out,
    input wire logic        wakeup_out
);
    logic       a_v_reg;
    logic       a_w_reg;
    logic       d_rd_reg;
    logic [7:0] a_idx_reg;
    logic [7:0] d_idx_reg;
    logic [7:0] low_buf_reg;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // follows taken transfers into data phase and read result
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            a_v_reg <= 1'b0;
            d_rd_reg <= 1'b0;
            low_buf_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            a_v_reg <= hsel_in && hready_in && htrans_in[1];
            a_w_reg <= hwrite_in;
            a_idx_reg <= haddr_in[9:2];
            d_rd_reg <= a_v_reg && !a_w_reg;
            d_idx_reg <= a_idx_reg;
            if (a_v_reg && a_w_reg && a_idx_reg == `IDX_C0_LOW)
                low_buf_reg <= hwdata_in[7:0];
        end
    end
    a_slave_okay: assert property (!hresp_out && (hreadyout_out || $past(hreadyout_out)))
        else $error("slave not okay or wait longer than one cycle");
    a_reset_quiet: assert property ($rose(arst_n_in) |-> !irq_out && !wakeup_out
        && hrdata_out == 32'h0000_0000) else $error("outputs not quiet after reset");
    a_wake_pulse: assert property (wakeup_out && clk_en_in |=> !wakeup_out)
        else $error("wake pulse longer than one cycle");
    a_low_buffer: assert property (d_rd_reg && d_idx_reg == `IDX_C0_LOW |->
        hrdata_out[7:0] == low_buf_reg) else $error("low byte read not the buffer");
    a_ctrl_unused: assert property (d_rd_reg && d_idx_reg inside {`IDX_C0_CTRL,
        `IDX_C1_CTRL} |-> hrdata_out[2:0] == 3'h0 && !hrdata_out[5])
        else $error("unused control bits not zero");
    a_unmapped_zero: assert property (d_rd_reg && !(d_idx_reg inside {[8'h0B:8'h11],
        8'h30, 8'h31}) |-> hrdata_out == 32'h0000_0000) else $error("unmapped read not zero");
    a_freeze_hold: assert property (!clk_en_in |=> $stable(irq_out) && $stable(hrdata_out))
        else $error("state moved while frozen");
    a_irq_disabled: assert property (a_v_reg && a_w_reg && a_idx_reg == `IDX_INT_CTRL
        && hwdata_in[3:2] == 2'b00 |-> ##2 !irq_out) else $error("irq with enables off");
endmodule : dual_timer_properties
bind dual_timer_event_counter dual_timer_properties chk (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .clk_en_in(clk_en_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .pin_in(pin_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .irq_out(irq_out), .wakeup_out(wakeup_out));
`default_nettype wire

/* testbench/tb_dual_timer_event_counter.sv */
// self-checking bench of the dual timer block
`include "dual_timer_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_dual_timer_event_counter;
    logic        mclk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        clk_en_in = 1'b1;
    logic        hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0000_0000;
    logic [1:0]  htrans_in = 2'h0;
    logic        hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0000_0000;
    logic [1:0]  pin_in;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic        irq_out;
    logic        wakeup_out;
    logic        wake_seen = 1'b0;
    logic [31:0] rd;
    int          bad_count = 0;
    int          comparisons = 0;
    int          seed = 71541;
    int          n;
    int          t;
    int          i;
    pin_source_model pins (.mclk_in(mclk_in), .pin_out(pin_in));
    dual_timer_event_counter dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .pin_in(pin_in), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_out(irq_out),
        .wakeup_out(wakeup_out));
    // clock and wake pulse watcher
    initial forever #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (wakeup_out === 1'b1) wake_seen <= 1'b1;
    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // waits for hready under a bound
    task automatic wait_ready();
        int k;
        @(posedge mclk_in);
        for (k = 0; k < 50 && hreadyout_out !== 1'b1; k++) @(posedge mclk_in);
        if (k >= 50)
        begin
            bad_count++;
            finish_test();
        end
    endtask : wait_ready
    // one single word transfer, read data taken at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in <= {22'h0, idx, 2'h0};
        wait_ready();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, wd};
        wait_ready();
        rd = hrdata_out;
    endtask : bus
    initial
    begin
        repeat (2) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        @(posedge mclk_in);
        for (i = 0; i < 2; i++)
        begin
            bus(1'b0, 8'h0E + 8'(3 * i), 8'h00);
            `CHK(rd[7:0], 8'h08)
        end
        bus(1'b0, 8'h20, 8'h00);
        `CHK(rd, 32'h0000_0000)
        t = $random(seed);
        bus(1'b1, 8'h0C, t[7:0]);
        bus(1'b0, 8'h0D, 8'h00);
        `CHK(rd[7:0], 8'h00)
        bus(1'b1, 8'h0D, t[15:8]);
        bus(1'b0, 8'h0D, 8'h00);
        `CHK(rd[7:0], t[15:8])
        bus(1'b0, 8'h0C, 8'h00);
        `CHK(rd[7:0], t[7:0])
        bus(1'b1, `IDX_INT_MASK, 8'h03);
        bus(1'b1, `IDX_INT_CTRL, 8'h0C);
        bus(1'b1, 8'h0C, 8'hF0);
        bus(1'b1, 8'h0D, 8'hFF);
        bus(1'b1, 8'h0E, 8'h90);
        clk_en_in <= 1'b0;
        repeat (5) @(posedge mclk_in);
        clk_en_in <= 1'b1;
        for (t = 0; t < 200 && irq_out !== 1'b1; t++) @(posedge mclk_in);
        `CHK(t > (65536 - 'hFFF0) * 4 - 10 && t < (65536 - 'hFFF0) * 4 + 10, 1'b1)
        `CHK(wake_seen, 1'b1)
        bus(1'b0, 8'h0E, 8'h00);
        `CHK(rd[4], 1'b1)
        bus(1'b1, 8'h0E, 8'h80);
        bus(1'b0, `IDX_INT_CTRL, 8'h00);
        `CHK(rd[5], 1'b1)
        bus(1'b1, `IDX_INT_CTRL, 8'h00);
        repeat (2) @(posedge mclk_in);
        `CHK(irq_out, 1'b0)
        bus(1'b1, `IDX_INT_CTRL, 8'h0C);
        for (i = 0; i < 2; i++)
        begin
            n = 2 + $unsigned($random(seed)) % 6;
            t = 65536 - n;
            bus(1'b1, 8'h11, 8'h00);
            bus(1'b1, 8'h0F, t[7:0]);
            bus(1'b1, 8'h10, t[15:8]);
            bus(1'b1, 8'h11, 8'h50 + 8'(8 * i));
            bus(1'b1, `IDX_INT_STATUS, 8'h03);
            repeat (n - 1)
            begin
                pins.drive(1, 1'b1, 3);
                pins.drive(1, 1'b0, 3);
            end
            pins.drive(1, 1'b1, 6);
            bus(1'b0, `IDX_INT_STATUS, 8'h00);
            `CHK(rd[1], i == 0)
            pins.drive(1, 1'b0, 6);
            bus(1'b0, `IDX_INT_STATUS, 8'h00);
            `CHK(rd[1], 1'b1)
        end
        bus(1'b1, 8'h0C, 8'hF8);
        bus(1'b1, 8'h0D, 8'hFF);
        bus(1'b1, 8'h0E, 8'hD8);
        bus(1'b1, `IDX_INT_STATUS, 8'h03);
        pins.drive(0, 1'b1, 48);
        pins.drive(0, 1'b0, 8);
        bus(1'b0, `IDX_INT_STATUS, 8'h00);
        `CHK(rd[0], 1'b1)
        bus(1'b0, 8'h0E, 8'h00);
        `CHK(rd[4], 1'b0)
        bus(1'b1, `IDX_INT_STATUS, 8'h03);
        pins.drive(0, 1'b1, 60);
        pins.drive(0, 1'b0, 8);
        bus(1'b0, `IDX_INT_STATUS, 8'h00);
        `CHK(rd[0], 1'b0)
        bus(1'b1, 8'h0E, 8'hD8);
        bus(1'b1, `IDX_INT_STATUS, 8'h03);
        pins.drive(0, 1'b1, 48);
        pins.drive(0, 1'b0, 8);
        bus(1'b0, `IDX_INT_STATUS, 8'h00);
        `CHK(rd[0], 1'b1)
        bus(1'b1, 8'h11, 8'h00);
        bus(1'b1, 8'h0F, 8'hFF);
        bus(1'b1, 8'h10, 8'hFF);
        bus(1'b1, 8'h11, 8'h18);
        bus(1'b1, `IDX_INT_STATUS, 8'h03);
        pins.drive(1, 1'b1, 8);
        pins.drive(1, 1'b0, 40);
        bus(1'b0, `IDX_INT_STATUS, 8'h00);
        `CHK(rd[1], 1'b0)
        finish_test();
    end
endmodule : tb_dual_timer_event_counter
`default_nettype wire
